//--- rtl/pwm_output_stop_and_protect.sv
// Output stop, write protected output mode and output enable logic of a six output PWM timer
`timescale 1ns/1ps
module pwm_output_stop_and_protect #(
   parameter int N_OUT = 6                        // Number of pulse outputs
) (
   input  wire logic                     i_clock,      // Peripheral clock, 125 MHz
   input  wire logic                     i_rst_n,      // Asynchronous reset, active low
   input  wire logic [31:0]              i_addr,       // CPU register address
   input  wire logic                     i_wr,         // CPU write strobe
   input  wire logic                     i_rd,         // CPU read strobe
   input  wire logic [7:0]               i_wdata,      // CPU byte write data
   input  wire pwm_stop_pkg::write_op_t  i_wr_op,      // Store or bit set/clear/invert
   input  wire logic [2:0]               i_bit_idx,    // Bit index for bit operations
   input  wire logic                     i_emergency_stop_in, // Emergency stop input
   input  wire logic                     i_counter_run,// Timer counting
   input  wire logic [N_OUT-1:0]         i_pwm_wave,   // Waveforms from the generator
   output logic [7:0]                    o_rdata,      // Read data, registered
   output logic                          o_rvalid,     // Read data valid pulse
   output logic [N_OUT-1:0]              o_pulse_out,  // Pulse output levels
   output logic [N_OUT-1:0]              o_pulse_oe,   // Pulse output enables
   output logic                          o_stopped     // Forced stop status
);
   import pwm_stop_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (N_OUT != NUM_OUTPUTS) begin : g_bad_width
      $error("N_OUT must equal the six outputs the register fields serve");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]       output_mode_reg;
   logic [7:0]       output_enable_reg;
   logic             unlocked;
   logic             stopped;
   logic [7:0]       rdata;
   logic             rvalid;
   logic [N_OUT-1:0] pulse_out;
   logic [N_OUT-1:0] pulse_oe;
   logic [7:0]       next_output_mode_reg;
   logic [7:0]       next_output_enable_reg;
   logic             next_unlocked;
   logic             next_stopped;
   logic [7:0]       next_rdata;
   logic             next_rvalid;
   logic [N_OUT-1:0] next_pulse_out;
   logic [N_OUT-1:0] next_pulse_oe;
   logic             trigger;
   logic             access;
   logic [7:0]       ctrl_wbyte;

   // Trigger detector on the emergency stop input
   stop_detect u_stop_detect (
      .i_clock   (i_clock),
      .i_rst_n   (i_rst_n),
      .i_stop_in (i_emergency_stop_in),
      .i_trig_sel(output_mode_reg[1:0]),
      .o_trigger (trigger)
   );

   // Applies a store or single bit operation to a byte
   function automatic logic [7:0] apply_op(input logic [7:0] old_val, input write_op_t op,
                                           input logic [2:0] idx, input logic [7:0] data);
      logic [7:0] bit_mask;
      bit_mask = 8'h01 << idx;
      case (op)
         OP_STORE:  apply_op = data;
         OP_SET:    apply_op = old_val | bit_mask;
         OP_CLEAR:  apply_op = old_val & ~bit_mask;
         OP_INVERT: apply_op = old_val ^ bit_mask;
         default:   apply_op = old_val;
      endcase
   endfunction

   assign access = i_wr | i_rd;

   // Stop control write byte; bit operations act on a zero byte
   assign ctrl_wbyte = apply_op(8'h00, i_wr_op, i_bit_idx, i_wdata);

   // ----------------------------------------------------------------
   // Register writes, unlock sequence and stop latch
   // ----------------------------------------------------------------
   always_comb begin
      next_output_mode_reg   = output_mode_reg;
      next_output_enable_reg = output_enable_reg;
      next_unlocked          = unlocked;
      next_stopped           = stopped;
      // Any access consumes a pending unlock; an unlock write rearms it
      if (access) begin
         next_unlocked = 1'b0;
      end
      if (i_wr && i_addr == ADDR_WRITE_UNLOCK) begin
         next_unlocked = 1'b1;
      end
      // Protected mode write only lands as the next access after the unlock write
      if (i_wr && i_addr == ADDR_OUTPUT_MODE && unlocked) begin
         next_output_mode_reg = apply_op(output_mode_reg, i_wr_op, i_bit_idx, i_wdata)
                                & MODE_WRITE_MASK;
      end
      // Output enable accepts byte stores and bit operations freely
      if (i_wr && i_addr == ADDR_OUTPUT_ENABLE) begin
         next_output_enable_reg = apply_op(output_enable_reg, i_wr_op, i_bit_idx, i_wdata)
                                  & ENABLE_WRITE_MASK;
      end
      // Release by writing 1; a trigger in the same cycle still wins
      if (i_wr && i_addr == ADDR_STOP_CONTROL && ctrl_wbyte[CTRL_RELEASE_BIT]) begin
         next_stopped = 1'b0;
      end
      if (trigger && !output_mode_reg[MODE_STOP_DIS_BIT]) begin
         next_stopped = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      next_rvalid = i_rd;
      next_rdata  = 8'h00;
      if (i_rd) begin
         case (i_addr)
            ADDR_OUTPUT_MODE:   next_rdata = output_mode_reg;
            ADDR_OUTPUT_ENABLE: next_rdata = output_enable_reg;
            ADDR_STOP_CONTROL:  next_rdata[CTRL_STATUS_BIT] = stopped;
            default:            next_rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output stage, one generate entry per pulse output
   // ----------------------------------------------------------------
   for (genvar g = 0; g < N_OUT; g++) begin : g_out
      always_comb begin
         next_pulse_oe[g] = output_enable_reg[g];
         // Stopped or idle outputs sit at the inactive level; counting continues
         if (stopped || !i_counter_run) begin
            next_pulse_out[g] = ~output_mode_reg[MODE_ACTIVE_HIGH_BIT];
         end else begin
            next_pulse_out[g] = i_pwm_wave[g];
         end
      end
   end

   // Register update
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         output_mode_reg   <= MODE_RESET;
         output_enable_reg <= ENABLE_RESET;
         unlocked          <= 1'b0;
         stopped           <= 1'b0;
         rdata             <= 8'h00;
         rvalid            <= 1'b0;
         pulse_out         <= '0;
         pulse_oe          <= '0;
      end else begin
         output_mode_reg   <= next_output_mode_reg;
         output_enable_reg <= next_output_enable_reg;
         unlocked          <= next_unlocked;
         stopped           <= next_stopped;
         rdata             <= next_rdata;
         rvalid            <= next_rvalid;
         pulse_out         <= next_pulse_out;
         pulse_oe          <= next_pulse_oe;
      end
   end

   assign o_rdata     = rdata;
   assign o_rvalid    = rvalid;
   assign o_pulse_out = pulse_out;
   assign o_pulse_oe  = pulse_oe;
   assign o_stopped   = stopped;
endmodule // pwm_output_stop_and_protect

//--- shared/pwm_stop_pkg.sv
// Package of register map, field positions and reset values for the output stop and protect logic
package pwm_stop_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_OUTPUT_MODE   = 32'hFFFFF57D;
   localparam logic [31:0] ADDR_WRITE_UNLOCK  = 32'hFFFFF57C;
   localparam logic [31:0] ADDR_OUTPUT_ENABLE = 32'hFFFFF57F;
   localparam logic [31:0] ADDR_STOP_CONTROL  = 32'hFFFFF57E;

   // ----------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------
   localparam int          MODE_ACTIVE_HIGH_BIT = 7;
   localparam int          MODE_STOP_DIS_BIT    = 3;
   localparam logic [7:0]  MODE_WRITE_MASK      = 8'hFB;  // Bit 2 reads zero
   localparam logic [7:0]  ENABLE_WRITE_MASK    = 8'h3F;  // Bits 7:6 read zero
   localparam int          CTRL_RELEASE_BIT     = 0;      // Write 1 to release
   localparam int          CTRL_STATUS_BIT      = 1;      // Reads stop status
   localparam int          NUM_OUTPUTS          = 6;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  MODE_RESET   = 8'h00;
   localparam logic [7:0]  ENABLE_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Trigger codes and bus write kinds
   // ----------------------------------------------------------------
   localparam logic [1:0]  TRIG_RISING  = 2'h0;
   localparam logic [1:0]  TRIG_FALLING = 2'h1;
   localparam logic [1:0]  TRIG_LOW     = 2'h2;

   typedef enum logic [1:0] {OP_STORE, OP_SET, OP_CLEAR, OP_INVERT} write_op_t;
endpackage

//--- rtl/stop_detect.sv
// Emergency stop input trigger detector
`timescale 1ns/1ps
module stop_detect (
   input  wire logic       i_clock,      // Peripheral clock
   input  wire logic       i_rst_n,      // Asynchronous reset, active low
   input  wire logic       i_stop_in,    // Emergency stop input level
   input  wire logic [1:0] i_trig_sel,   // Trigger select code
   output logic            o_trigger     // Valid trigger seen this cycle
);
   import pwm_stop_pkg::*;

   logic prev_in;
   logic next_prev_in;

   // ----------------------------------------------------------------
   // Trigger decode
   // ----------------------------------------------------------------
   always_comb begin
      next_prev_in = i_stop_in;
      case (i_trig_sel)
         TRIG_RISING:  o_trigger = i_stop_in & ~prev_in;
         TRIG_FALLING: o_trigger = ~i_stop_in & prev_in;
         TRIG_LOW:     o_trigger = ~i_stop_in;
         default:      o_trigger = 1'b0;
      endcase
   end

   // Previous sample of the input, starts high so a held high does not look like a rising edge
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_in <= 1'b1;
      end else begin
         prev_in <= next_prev_in;
      end
   end
endmodule // stop_detect

//--- dv/pwm_stop_checker_assertions.sv
// Checker of read timing, enable updates and stop latch relations
`timescale 1ns/1ps
module pwm_stop_checker #(
   parameter int N_OUT = 6                       // Number of pulse outputs
) (
   input  wire logic                     i_clock,     // Clock
   input  wire logic                     i_rst_n,     // Reset, active low
   input  wire logic [31:0]              i_addr,      // Address
   input  wire logic                     i_wr,        // Write strobe
   input  wire logic                     i_rd,        // Read strobe
   input  wire logic [7:0]               i_wdata,     // Write data
   input  wire pwm_stop_pkg::write_op_t  i_wr_op,     // Write kind
   input  wire logic [2:0]               i_bit_idx,   // Bit index
   input  wire logic                     i_emergency_stop_in, // Stop input
   input  wire logic                     i_counter_run, // Counting
   input  wire logic [N_OUT-1:0]         i_pwm_wave,  // Waveforms
   input  wire logic [7:0]               o_rdata,     // Read data
   input  wire logic                     o_rvalid,    // Read valid
   input  wire logic [N_OUT-1:0]         o_pulse_out, // Output levels
   input  wire logic [N_OUT-1:0]         o_pulse_oe,  // Output enables
   input  wire logic                     o_stopped    // Stop status
);
   import pwm_stop_pkg::*;
   logic en_wr;
   logic rel_wr;
   // Writes toward the enable register and release writes toward stop control
   assign en_wr  = i_wr && (i_addr == ADDR_OUTPUT_ENABLE);
   assign rel_wr = i_wr && (i_addr == ADDR_STOP_CONTROL) &&
                   ((i_wr_op == OP_STORE) ? i_wdata[0] : (i_wr_op != OP_CLEAR && i_bit_idx == 3'h0));
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   a_read_answer: assert property (i_rd |=> o_rvalid) else $error("read not answered");
   a_read_idle: assert property (!i_rd |=> !o_rvalid) else $error("stray read valid");
   a_rdata_zero: assert property (!o_rvalid |-> o_rdata == 8'h00) else $error("read data not zero");
   // Enables reach the pins through the register and then the output flop: two cycles
   a_oe_store: assert property (en_wr && i_wr_op == OP_STORE |-> ##2
      o_pulse_oe == $past(i_wdata[N_OUT-1:0], 2)) else $error("enable store lost");
   a_oe_bit_set: assert property (en_wr && i_wr_op == OP_SET |-> ##2
      o_pulse_oe == ($past(o_pulse_oe) | (N_OUT'(1) << $past(i_bit_idx, 2)))) else $error("enable set wrong");
   a_oe_bit_clear: assert property (en_wr && i_wr_op == OP_CLEAR |-> ##2
      o_pulse_oe == ($past(o_pulse_oe) & ~(N_OUT'(1) << $past(i_bit_idx, 2)))) else $error("enable clear wrong");
   a_oe_hold: assert property (!en_wr |-> ##2 $stable(o_pulse_oe)) else $error("enable changed alone");
   a_stop_latch: assert property (o_stopped && !rel_wr |=> o_stopped) else $error("stop dropped");
   a_stop_level: assert property (o_stopped ##1 o_stopped |-> o_pulse_out == {N_OUT{o_pulse_out[0]}})
      else $error("stopped outputs differ");
   a_stop_cause: assert property ($rose(o_stopped) |-> !$past(i_emergency_stop_in) ||
      ($past(i_emergency_stop_in) != $past(i_emergency_stop_in, 2))) else $error("stop without cause");
   a_run_follow: assert property (!o_stopped && i_counter_run |=> o_pulse_out == $past(i_pwm_wave))
      else $error("running output wrong");
endmodule // pwm_stop_checker

//--- dv/estop_source.sv
// Partner model of the external emergency stop line
`timescale 1ns/1ps
module estop_source (
   input  wire logic i_clock,   // Peripheral clock
   input  wire logic i_level,   // Commanded stop level
   output logic      o_stop     // Stop line toward the block
);
   // Idle high, changes launched on the falling edge away from sampling
   initial o_stop = 1'b1;
   always @(negedge i_clock) begin
      o_stop <= i_level;
   end
endmodule // estop_source

//--- dv/tb.sv
// Self-checking bench with a register model of the output stop and protect block
`timescale 1ns/1ps
module tb;
   import pwm_stop_pkg::*;
   logic [31:0] i_addr;
   logic        i_clock, i_rst_n, i_wr, i_rd, i_counter_run, stop_cmd, stop_line, o_rvalid, o_stopped;
   logic [7:0]  i_wdata, o_rdata;
   logic [2:0]  i_bit_idx;
   logic [5:0]  i_pwm_wave, o_pulse_out, o_pulse_oe;
   write_op_t   i_wr_op;
   int          fails, cmp_count, cycles, m_mode, m_en, m_unl, m_stop;
   // Clock and cycle ceiling
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fails = fails + 1;
         tally_and_finish();
      end
   end
   pwm_output_stop_and_protect #(.N_OUT(6)) i_pwm_output_stop_and_protect (.i_clock, .i_rst_n, .i_addr, .i_wr,
      .i_rd, .i_wdata, .i_wr_op, .i_bit_idx, .i_emergency_stop_in(stop_line), .i_counter_run, .i_pwm_wave,
      .o_rdata, .o_rvalid, .o_pulse_out, .o_pulse_oe, .o_stopped);
   estop_source i_estop_source (.i_clock, .i_level(stop_cmd), .o_stop(stop_line));
   // Compare, model update and bus tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic int apply(int old, write_op_t op, int idx, int data, int mask);
      return mask & ((op == OP_STORE) ? data : (op == OP_SET) ? old | (1 << idx) :
                     (op == OP_CLEAR) ? old & ~(1 << idx) : old ^ (1 << idx));
   endfunction
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input write_op_t op, input logic [2:0] idx);
      @(negedge i_clock);
      i_addr = a;
      i_wdata = d;
      i_wr_op = op;
      i_bit_idx = idx;
      i_wr = 1'b1;
      if (a == ADDR_OUTPUT_MODE && m_unl != 0) m_mode = apply(m_mode, op, idx, d, MODE_WRITE_MASK);
      if (a == ADDR_OUTPUT_ENABLE) m_en = apply(m_en, op, idx, d, ENABLE_WRITE_MASK);
      m_unl = (a == ADDR_WRITE_UNLOCK);
      @(negedge i_clock);
      i_wr = 1'b0;
      // Enable pins follow the register one cycle later
      @(negedge i_clock);
      chk({2'h0, o_pulse_oe}, m_en[7:0]);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] exp);
      @(negedge i_clock);
      i_addr = a;
      i_rd = 1'b1;
      m_unl = 0;
      @(negedge i_clock);
      i_rd = 1'b0;
      chk({7'h0, o_rvalid}, 8'h01);
      chk(o_rdata, exp);
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d of %0d compares", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial begin
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 32'h0;
      i_wdata = 8'h00;
      i_wr_op = OP_STORE;
      i_bit_idx = 3'h0;
      i_counter_run = 1'b0;
      i_pwm_wave = 6'h00;
      stop_cmd = 1'b1;
      void'($urandom(32'h666A6C10));
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      i_rst_n = 1'b1;
      rd(ADDR_OUTPUT_MODE, 8'h00);
      rd(ADDR_OUTPUT_ENABLE, 8'h00);
      rd(32'hFFFFF570, 8'h00);
      // Enable stores and every bit operation on every bit
      repeat (4) wr(ADDR_OUTPUT_ENABLE, 8'($urandom), OP_STORE, 3'h0);
      for (int i = 0; i < 24; i++) wr(ADDR_OUTPUT_ENABLE, 8'h00, write_op_t'(1 + i % 3), 3'(i / 3));
      rd(ADDR_OUTPUT_ENABLE, m_en[7:0]);
      // Locked write, cancelled unlock, then each unlocked write kind
      wr(ADDR_OUTPUT_MODE, 8'h80, OP_STORE, 3'h0);
      wr(ADDR_WRITE_UNLOCK, 8'h80, OP_STORE, 3'h0);
      rd(ADDR_OUTPUT_ENABLE, m_en[7:0]);
      wr(ADDR_OUTPUT_MODE, 8'h80, OP_STORE, 3'h0);
      rd(ADDR_OUTPUT_MODE, m_mode[7:0]);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_WRITE_UNLOCK, 8'hF7, OP_STORE, 3'h0);
         wr(ADDR_OUTPUT_MODE, 8'hF7, write_op_t'(i), 3'(4 + i));
         rd(ADDR_OUTPUT_MODE, m_mode[7:0]);
      end
      // Running timer: outputs follow the random waveforms while not stopped
      for (int i = 0; i < 4; i++) begin
         @(negedge i_clock);
         i_counter_run = 1'b1;
         i_pwm_wave = 6'($urandom);
         @(negedge i_clock);
         chk({2'h0, o_pulse_out}, {2'h0, i_pwm_wave});
      end
      i_pwm_wave = 6'h00;
      // Each trigger code, then the input ignored with the disable bit set
      for (int c = 0; c < 5; c++) begin
         wr(ADDR_STOP_CONTROL, 8'h01, OP_STORE, 3'h0);
         wr(ADDR_WRITE_UNLOCK, (c == 4) ? 8'h09 : 8'(c), OP_STORE, 3'h0);
         wr(ADDR_OUTPUT_MODE, (c == 4) ? 8'h09 : 8'(c), OP_STORE, 3'h0);
         m_stop = (c < 3);
         @(posedge i_clock) stop_cmd = 1'b0;
         repeat (3) @(negedge i_clock);
         @(posedge i_clock) stop_cmd = 1'b1;
         repeat (3) @(negedge i_clock);
         chk({7'h0, o_stopped}, 8'(m_stop));
         chk({2'h0, o_pulse_out}, (m_stop != 0) ? 8'h3F : {2'h0, i_pwm_wave});
         rd(ADDR_STOP_CONTROL, 8'(m_stop << 1));
      end
      wr(ADDR_STOP_CONTROL, 8'h01, OP_STORE, 3'h0);
      chk({7'h0, o_stopped}, 8'h00);
      tally_and_finish();
   end
endmodule // tb
bind pwm_output_stop_and_protect pwm_stop_checker #(.N_OUT(N_OUT)) u_checker (.i_clock, .i_rst_n, .i_addr,
   .i_wr, .i_rd, .i_wdata, .i_wr_op, .i_bit_idx, .i_emergency_stop_in, .i_counter_run, .i_pwm_wave, .o_rdata,
   .o_rvalid, .o_pulse_out, .o_pulse_oe, .o_stopped);
